// >>> verilog/flash_status_pkg.sv
// Purpose: shared types, bit layout and instruction codes of the status and write-enable logic
// Assumes: 8-bit instruction codes, one status byte
// Notes: the busy-state allow list codes that have no fixed value are parameters of the top module
package flash_status_pkg;

  // status byte layout, msb first: lock, quad, protect[3:0], latch, busy
  typedef struct packed {
    logic status_write_lock;
    logic quad_enable;
    logic [3:0] block_protect;
    logic write_enable_latch;
    logic busy_flag;
  } status_t;

  localparam int SR_BUSY_BIT = 0;
  localparam int SR_LATCH_BIT = 1;
  localparam int SR_NV_LSB = 2;
  localparam int SR_NV_MSB = 7;
  localparam status_t STATUS_RESET = 8'h00;
  localparam logic [3:0] BP_NONE = 4'h0;

  // one instruction as it crosses from the link: code plus first data byte
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_BUSY = 3'b010,
    ST_SUSP = 3'b100
  } op_state_t;

  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] SUSPEND_CMD = 8'h75;
  localparam logic [7:0] RESUME_CMD = 8'h7A;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] PAGE_PROGRAM_4B_CMD = 8'h12;
  localparam logic [7:0] QUAD_IN_PROGRAM_CMD = 8'h32;
  localparam logic [7:0] QUAD_IN_PROGRAM_4B_CMD = 8'h34;
  localparam logic [7:0] QUAD_IO_PROGRAM_CMD = 8'h38;
  localparam logic [7:0] QUAD_IO_PROGRAM_4B_CMD = 8'h3E;
  localparam logic [7:0] SMALL_SECTOR_ERASE_CMD = 8'hD7;
  localparam logic [7:0] SMALL_SECTOR_ERASE_ALT_CMD = 8'h20;
  localparam logic [7:0] SMALL_SECTOR_ERASE_4B_CMD = 8'h21;
  localparam logic [7:0] BLOCK_ERASE_32K_CMD = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_32K_4B_CMD = 8'h5C;
  localparam logic [7:0] BLOCK_ERASE_64K_CMD = 8'hD8;
  localparam logic [7:0] BLOCK_ERASE_64K_4B_CMD = 8'hDC;
  localparam logic [7:0] WHOLE_CHIP_ERASE_CMD = 8'hC7;
  localparam logic [7:0] WHOLE_CHIP_ERASE_ALT_CMD = 8'h60;
  localparam logic [7:0] FUNCTION_REG_WRITE_CMD = 8'h42;
  localparam logic [7:0] READ_PARAM_NONVOLATILE_CMD = 8'h65;
  localparam logic [7:0] EXT_READ_PARAM_NONVOLATILE_CMD = 8'h85;
  localparam logic [7:0] EXT_READ_PARAM_VOLATILE_CMD = 8'h83;
  localparam logic [7:0] INFO_ROW_ERASE_CMD = 8'h64;
  localparam logic [7:0] INFO_ROW_PROGRAM_CMD = 8'h62;
  localparam logic [7:0] BOOT_REG_WRITE_CMD = 8'h15;
  localparam logic [7:0] BANK_REG_NONVOLATILE_WRITE_CMD = 8'h18;
  localparam logic [7:0] DYNAMIC_LOCK_WRITE_CMD = 8'hFB;
  localparam logic [7:0] DYNAMIC_LOCK_WRITE_ALT_CMD = 8'hE1;
  localparam logic [7:0] PERSISTENT_LOCK_WRITE_CMD = 8'hFD;
  localparam logic [7:0] PERSISTENT_LOCK_WRITE_ALT_CMD = 8'hE3;
  localparam logic [7:0] PERSISTENT_LOCK_ERASE_CMD = 8'hE4;
  localparam logic [7:0] PROTECTION_MODE_PROGRAM_CMD = 8'h2F;
  localparam logic [7:0] PERSISTENT_LOCK_BIT_WRITE_CMD = 8'hA6;
  localparam logic [7:0] FREEZE_SET_CMD = 8'h91;
  localparam logic [7:0] GANG_LOCK_CMD = 8'h7E;
  localparam logic [7:0] GANG_UNLOCK_CMD = 8'h98;
  localparam logic [7:0] PASSWORD_PROGRAM_CMD = 8'hE8;
  localparam logic [7:0] TRAINING_PATTERN_NONVOLATILE_CMD = 8'h43;
  localparam logic [7:0] TRAINING_PATTERN_VOLATILE_CMD = 8'h4A;

  function automatic logic is_prog_erase(input logic [7:0] c);
    return c inside {PAGE_PROGRAM_CMD, PAGE_PROGRAM_4B_CMD, QUAD_IN_PROGRAM_CMD, QUAD_IN_PROGRAM_4B_CMD,
                     QUAD_IO_PROGRAM_CMD, QUAD_IO_PROGRAM_4B_CMD, SMALL_SECTOR_ERASE_CMD,
                     SMALL_SECTOR_ERASE_ALT_CMD, SMALL_SECTOR_ERASE_4B_CMD, BLOCK_ERASE_32K_CMD,
                     BLOCK_ERASE_32K_4B_CMD, BLOCK_ERASE_64K_CMD, BLOCK_ERASE_64K_4B_CMD,
                     WHOLE_CHIP_ERASE_CMD, WHOLE_CHIP_ERASE_ALT_CMD};
  endfunction

  function automatic logic is_reg_write(input logic [7:0] c);
    return c inside {STATUS_WRITE_CMD, FUNCTION_REG_WRITE_CMD, READ_PARAM_NONVOLATILE_CMD,
                     EXT_READ_PARAM_NONVOLATILE_CMD, EXT_READ_PARAM_VOLATILE_CMD, INFO_ROW_ERASE_CMD,
                     INFO_ROW_PROGRAM_CMD, BOOT_REG_WRITE_CMD, BANK_REG_NONVOLATILE_WRITE_CMD,
                     DYNAMIC_LOCK_WRITE_CMD, DYNAMIC_LOCK_WRITE_ALT_CMD, PERSISTENT_LOCK_WRITE_CMD,
                     PERSISTENT_LOCK_WRITE_ALT_CMD, PERSISTENT_LOCK_ERASE_CMD, PROTECTION_MODE_PROGRAM_CMD,
                     PERSISTENT_LOCK_BIT_WRITE_CMD, FREEZE_SET_CMD, GANG_LOCK_CMD, GANG_UNLOCK_CMD,
                     PASSWORD_PROGRAM_CMD, TRAINING_PATTERN_NONVOLATILE_CMD, TRAINING_PATTERN_VOLATILE_CMD};
  endfunction

  // volatile writes finish at once and never raise the busy flag
  function automatic logic is_volatile_write(input logic [7:0] c);
    return c inside {EXT_READ_PARAM_VOLATILE_CMD, TRAINING_PATTERN_VOLATILE_CMD};
  endfunction

endpackage

// >>> verilog/word_handshake_cdc.sv
// Purpose: carries one word at a time between two unrelated clocks by a toggle handshake
// Assumes: source holds nothing; the word is captured on acceptance
// Notes: one word in flight; src_ready stays low until the far side has acknowledged
`timescale 1ns/1ns
module word_handshake_cdc #(
  parameter int WIDTH = 16
) (
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic src_valid,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_ready,
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data
);

  if (WIDTH < 1) begin : g_bad_width
    $error("word_handshake_cdc needs a width of at least one");
  end

  typedef struct packed {
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [WIDTH-1:0] data;
  } src_state_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic valid;
    logic [WIDTH-1:0] data;
  } dst_state_t;

  src_state_t src_reg, src_next;
  dst_state_t dst_reg, dst_next;

  assign src_ready = (src_reg.req == src_reg.ack_s2);
  assign dst_valid = dst_reg.valid;
  assign dst_data = dst_reg.data;

  always_comb begin
    src_next = src_reg;
    src_next.ack_s1 = dst_reg.ack;
    src_next.ack_s2 = src_reg.ack_s1;
    if (src_valid && src_ready) begin
      src_next.req = ~src_reg.req;
      src_next.data = src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      src_reg <= '0;
    end else begin
      src_reg <= src_next;
    end
  end

  // the source word has been still for two destination edges when req_s2 moves
  always_comb begin
    dst_next = dst_reg;
    dst_next.req_s1 = src_reg.req;
    dst_next.req_s2 = dst_reg.req_s1;
    dst_next.valid = 1'b0;
    if (dst_reg.req_s2 != dst_reg.ack) begin
      dst_next.ack = dst_reg.req_s2;
      dst_next.valid = 1'b1;
      dst_next.data = src_reg.data;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      dst_reg <= '0;
    end else begin
      dst_reg <= dst_next;
    end
  end

endmodule // word_handshake_cdc

// >>> verilog/flash_status_write_enable.sv
// Purpose: status byte, write-enable latch and instruction gating of the serial flash
// Assumes: framing is decoded elsewhere; one instruction arrives per link handshake
// Notes: the array core runs operations and reports op_done; status reads go back over the link
`timescale 1ns/1ns
module flash_status_write_enable #(
  parameter logic [7:0] WRITE_DISABLE_CODE = 8'h04,
  parameter logic [7:0] STATUS_READ_CODE = 8'h05,
  parameter logic [7:0] EXT_READ_CODE = 8'h81,
  parameter logic [7:0] SOFT_RESET_CODE = 8'h99
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire logic link_cmd_valid,
  input wire flash_status_pkg::cmd_t link_cmd,
  output logic link_cmd_ready,
  output flash_status_pkg::status_t link_status,
  input wire logic wp_pin_n,
  input wire logic op_done,
  output logic exec_valid,
  output flash_status_pkg::cmd_t exec_cmd,
  output flash_status_pkg::status_t status,
  output logic [3:0] block_protect,
  output logic quad_enable
);
  import flash_status_pkg::*;

  if (WRITE_DISABLE_CODE == WRITE_ENABLE_CMD || STATUS_READ_CODE == WRITE_ENABLE_CMD) begin : g_bad_codes
    $error("flash_status_write_enable: instruction codes collide");
  end

  typedef struct packed {
    op_state_t state;
    status_t sr;
    status_t sent;
    logic op_is_pe;
    logic wp_s1;
    logic wp_s2;
    logic exec_valid;
    cmd_t exec_cmd;
  } sys_state_t;

  sys_state_t s_reg, s_next;
  logic link_rst_s1, link_rst_b;
  logic cmd_in_valid;
  cmd_t cmd_in;
  logic sts_ready;
  logic [7:0] code;
  logic gated, pe, long_op, chip_erase, wp_low, reject_idle, busy_ok;

  // link reset follows the system reset through two link-clock flops
  always_ff @(posedge clk_link) begin
    link_rst_s1 <= rst_b;
    link_rst_b <= link_rst_s1;
  end

  word_handshake_cdc #(.WIDTH($bits(cmd_t))) u_cmd_cdc (
    .src_clk(clk_link),
    .src_rst_b(link_rst_b),
    .src_valid(link_cmd_valid),
    .src_data(link_cmd),
    .src_ready(link_cmd_ready),
    .dst_clk(clk_sys),
    .dst_rst_b(rst_b),
    .dst_valid(cmd_in_valid),
    .dst_data(cmd_in)
  );

  // status copy for the link; it lags by the handshake and waits if the link clock stops
  word_handshake_cdc #(.WIDTH($bits(status_t))) u_sts_cdc (
    .src_clk(clk_sys),
    .src_rst_b(rst_b),
    .src_valid(s_reg.sr != s_reg.sent),
    .src_data(s_reg.sr),
    .src_ready(sts_ready),
    .dst_clk(clk_link),
    .dst_rst_b(link_rst_b),
    .dst_valid(),
    .dst_data(link_status)
  );

  assign code = cmd_in.code;
  assign pe = is_prog_erase(code);
  assign gated = pe | is_reg_write(code);
  assign long_op = gated & ~is_volatile_write(code);
  assign chip_erase = (code == WHOLE_CHIP_ERASE_CMD) || (code == WHOLE_CHIP_ERASE_ALT_CMD);
  assign wp_low = ~s_reg.wp_s2;

  // latch gate; chip erase guard; hardware lock; no long operation while suspended
  assign reject_idle = (gated && !s_reg.sr.write_enable_latch)
                    || (chip_erase && s_reg.sr.block_protect != BP_NONE)
                    || (code == STATUS_WRITE_CMD && s_reg.sr.status_write_lock && wp_low)
                    || (s_reg.state == ST_SUSP && long_op);

  assign busy_ok = (code == STATUS_READ_CODE) || (code == EXT_READ_CODE) || (code == SOFT_RESET_CODE)
                || (code == SUSPEND_CMD && s_reg.op_is_pe);

  always_comb begin
    s_next = s_reg;
    s_next.wp_s1 = wp_pin_n;
    s_next.wp_s2 = s_reg.wp_s1;
    s_next.exec_valid = 1'b0;
    if (sts_ready && s_reg.sr != s_reg.sent) begin
      s_next.sent = s_reg.sr;
    end
    // completion frees the device and drops the latch
    if (s_reg.state == ST_BUSY && op_done) begin
      s_next.state = ST_READY;
      s_next.op_is_pe = 1'b0;
      s_next.sr.write_enable_latch = 1'b0;
    end
    if (cmd_in_valid) begin
      unique case (s_next.state)
        ST_READY, ST_SUSP: begin
          if (s_next.state == ST_SUSP && code == RESUME_CMD) begin
            s_next.state = ST_BUSY;
            s_next.exec_valid = 1'b1;
            s_next.exec_cmd = cmd_in;
          end else if (!reject_idle) begin
            s_next.exec_valid = 1'b1;
            s_next.exec_cmd = cmd_in;
            if (code == WRITE_ENABLE_CMD) begin
              s_next.sr.write_enable_latch = 1'b1;
            end
            if (code == WRITE_DISABLE_CODE) begin
              s_next.sr.write_enable_latch = 1'b0;
            end
            // status write leaves the latch alone
            if (code == STATUS_WRITE_CMD) begin
              s_next.sr.status_write_lock = cmd_in.data[SR_NV_MSB];
              s_next.sr.quad_enable = cmd_in.data[SR_NV_MSB-1];
              s_next.sr.block_protect = cmd_in.data[SR_NV_LSB+3:SR_NV_LSB];
            end
            if (long_op) begin
              s_next.state = ST_BUSY;
              s_next.op_is_pe = pe;
            end
          end
        end
        ST_BUSY: begin
          if (busy_ok) begin
            s_next.exec_valid = 1'b1;
            s_next.exec_cmd = cmd_in;
            if (code == SUSPEND_CMD) begin
              s_next.state = ST_SUSP;
            end
          end
        end
        default: s_next.state = ST_READY;
      endcase
    end
    s_next.sr.busy_flag = (s_next.state == ST_BUSY);
  end

  // all status bits zero from reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.state <= ST_READY;
      s_reg.sr <= STATUS_RESET;
      s_reg.sent <= STATUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign exec_valid = s_reg.exec_valid;
  assign exec_cmd = s_reg.exec_cmd;
  assign status = s_reg.sr;
  // protect bits to the array core
  assign block_protect = s_reg.sr.block_protect;
  // pin mux selects data lines from the quad bit
  assign quad_enable = s_reg.sr.quad_enable;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence sq_cmd(logic [7:0] c);
    cmd_in_valid && code == c;
  endsequence

  sequence sq_idle;
    s_reg.state != ST_BUSY && !(s_reg.state == ST_SUSP && code == RESUME_CMD);
  endsequence

  sequence sq_done;
    s_reg.state == ST_BUSY && op_done;
  endsequence

  a_write_enable_cmd_sets_latch: assert property (sq_cmd(WRITE_ENABLE_CMD) and sq_idle |=> status.write_enable_latch)
    else $error("write enable did not set the latch");

  a_write_disable_cmd_clears_latch: assert property (sq_cmd(WRITE_DISABLE_CODE) and sq_idle |=> !status.write_enable_latch)
    else $error("write disable did not clear the latch");

  a_busy_ignores_cmd: assert property (s_reg.state == ST_BUSY && !op_done && cmd_in_valid && !busy_ok
    |=> !exec_valid && status.busy_flag)
    else $error("instruction taken while busy");

  // a command in the completion cycle is judged afterwards and may set the latch again
  a_done_frees_device: assert property (sq_done and !cmd_in_valid |=> !status.busy_flag && !status.write_enable_latch)
    else $error("completion did not clear busy and latch");

  a_gate_discards: assert property (cmd_in_valid && gated && !status.write_enable_latch
    && s_reg.state == ST_READY |=> !exec_valid && $stable(status))
    else $error("gated instruction ran with latch low");

  a_chip_erase_guard: assert property (cmd_in_valid && chip_erase && status.block_protect != BP_NONE
    |=> !exec_valid)
    else $error("chip erase taken with protect bits set");

  a_status_lock: assert property (sq_cmd(STATUS_WRITE_CMD) and (status.status_write_lock && wp_low)
    |=> $stable(status[SR_NV_MSB:SR_NV_LSB]) && !exec_valid)
    else $error("locked status byte was written");

  a_status_write_cmd_keeps_latch: assert property (sq_cmd(STATUS_WRITE_CMD) and sq_idle and !reject_idle
    |=> status.write_enable_latch && status.busy_flag && status[SR_NV_MSB:SR_NV_LSB] == $past(cmd_in.data[7:2]))
    else $error("status write changed the latch or missed its bits");

  a_op_holds_busy: assert property (cmd_in_valid && long_op && s_reg.state == ST_READY && !reject_idle
    |=> status.busy_flag [*2] or (status.busy_flag ##1 !status.busy_flag && $past(op_done)))
    else $error("long operation did not hold busy");

  a_suspend_taken: assert property (sq_cmd(SUSPEND_CMD) and (s_reg.state == ST_BUSY && s_reg.op_is_pe && !op_done)
    |=> exec_valid && !status.busy_flag ##1 !status.busy_flag)
    else $error("suspend not accepted during program or erase");

  a_reset_zero: assert property (disable iff (1'b0) !rst_b |=> status == STATUS_RESET)
    else $error("status not zero after reset");

endmodule // flash_status_write_enable

// >>> bench/flash_host_model.sv
// Purpose: serial host side of the instruction link, one instruction per frame
// Assumes: the host makes the link clock and runs it only inside frames and idle gaps
// Notes: idle data toggles every cycle so a stale word is never mistaken for a live one
`timescale 1ns/1ns
module flash_host_model (
  output logic clk_link,
  output logic link_cmd_valid,
  output flash_status_pkg::cmd_t link_cmd,
  input wire logic link_cmd_ready,
  output logic stuck
);
  import flash_status_pkg::*;

  initial begin
    clk_link = 1'b0;
    link_cmd_valid = 1'b0;
    link_cmd = 16'hA5A5;
    stuck = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) begin
      #32 clk_link = 1'b1;
      #32 clk_link = 1'b0;
      link_cmd = ~link_cmd;
    end
  endtask

  // offer held until an edge sees ready; bounded so a dead link cannot hang the run
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    int n;
    logic taken;
    n = 0;
    taken = 1'b0;
    #3;
    link_cmd_valid = 1'b1;
    link_cmd = {code, data};
    while (!taken && n < 40) begin
      #32 taken = (link_cmd_ready === 1'b1);
      clk_link = 1'b1;
      #32 clk_link = 1'b0;
      n++;
    end
    link_cmd_valid = 1'b0;
    link_cmd = ~link_cmd;
    if (!taken) stuck = 1'b1;
    idle(12);
  endtask
endmodule // flash_host_model

// >>> bench/flash_status_write_enable_tb.sv
// Purpose: self-checking bench of the status byte and write-enable latch
// Assumes: one instruction in flight; core completion modelled by op_done pulses
// Notes: driver queues each expected forward, a monitor pops it on exec_valid
`timescale 1ns/1ns
module flash_status_write_enable_tb;
  import flash_status_pkg::*;

  typedef struct packed {
    cmd_t c;
    status_t s;
  } note_t;

  localparam logic [7:0] WRITE_DISABLE_CMD_C = 8'h04;
  localparam logic [7:0] RDSR_C = 8'h05;
  localparam logic [7:0] XRD_C = 8'h81;
  localparam logic [7:0] SRST_C = 8'h99;

  logic clk_sys;
  logic rst_b;
  logic clk_link;
  logic link_cmd_valid;
  cmd_t link_cmd;
  logic link_cmd_ready;
  status_t link_status;
  logic wp_pin_n;
  logic op_done;
  logic exec_valid;
  cmd_t exec_cmd;
  status_t status;
  logic [3:0] block_protect;
  logic quad_enable;
  logic stuck;
  note_t notes[$];
  note_t nt;
  status_t cur;
  logic [7:0] d;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] gated_codes [35] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E, 8'hD7, 8'h20, 8'h21, 8'h52,
    8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, 8'h42, 8'h65, 8'h85, 8'h83, 8'h64, 8'h62, 8'h15, 8'h18, 8'hFB,
    8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'h43, 8'h4A};

  flash_status_write_enable #(.WRITE_DISABLE_CODE(WRITE_DISABLE_CMD_C), .STATUS_READ_CODE(RDSR_C), .EXT_READ_CODE(XRD_C),
    .SOFT_RESET_CODE(SRST_C)) flash_status_write_enable_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_link(clk_link), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_cmd_ready(link_cmd_ready),
    .link_status(link_status), .wp_pin_n(wp_pin_n), .op_done(op_done), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .status(status), .block_protect(block_protect), .quad_enable(quad_enable));

  flash_host_model flash_host_model_inst (.clk_link(clk_link), .link_cmd_valid(link_cmd_valid),
    .link_cmd(link_cmd), .link_cmd_ready(link_cmd_ready), .stuck(stuck));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (exec_valid === 1'b1) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: instruction %h forwarded unexpectedly", $time, exec_cmd);
      end else begin
        nt = notes.pop_front();
        chk(exec_cmd, nt.c, "forwarded instruction");
        chk({8'h00, status}, {8'h00, nt.s}, "status at acceptance");
      end
    end
  end

  task automatic st(input string msg);
    chk({8'h00, status}, {8'h00, cur}, msg);
    chk({8'h00, link_status}, {8'h00, cur}, msg);
    chk({12'h000, block_protect}, {12'h000, cur.block_protect}, msg);
    chk({15'h0000, quad_enable}, {15'h0000, cur.quad_enable}, msg);
  endtask

  // accepted instructions are noted first, discarded ones leave the state as it was
  task automatic cmd(input logic [7:0] code, input logic [7:0] data, input logic acc, input status_t nxt);
    if (acc) notes.push_back({code, data, nxt});
    flash_host_model_inst.send(code, data);
    if (stuck === 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: link never ready", $time);
      conclude();
    end
    cur = nxt;
    st("status after instruction");
  endtask

  task automatic done(input status_t nxt);
    @(negedge clk_sys) op_done = 1'b1;
    @(negedge clk_sys) op_done = 1'b0;
    @(negedge clk_sys);
    cur = nxt;
    chk({8'h00, status}, {8'h00, cur}, "status after completion");
  endtask

  initial begin
    rst_b = 1'b0;
    op_done = 1'b0;
    wp_pin_n = 1'b1;
    cur = STATUS_RESET;
    void'($urandom(39568));
    fork
      flash_host_model_inst.idle(4);
      repeat (10) @(negedge clk_sys);
    join
    @(negedge clk_sys) rst_b = 1'b1;
    flash_host_model_inst.idle(4);
    st("reset value");
    cmd(8'h02, 8'h00, 1'b0, cur);
    cmd(8'h06, 8'h00, 1'b1, 8'h02);
    cmd(WRITE_DISABLE_CMD_C, 8'h00, 1'b1, 8'h00);
    d = (8'($urandom) & 8'h7C) | 8'h04;
    cmd(8'h06, 8'h00, 1'b1, 8'h02);
    cmd(8'h01, d, 1'b1, d | 8'h03);
    cmd(8'h06, 8'h00, 1'b0, cur);
    cmd(RDSR_C, 8'h00, 1'b1, cur);
    cmd(XRD_C, 8'h00, 1'b1, cur);
    cmd(SRST_C, 8'h00, 1'b1, cur);
    done(d);
    cmd(8'h06, 8'h00, 1'b1, d | 8'h02);
    cmd(8'hC7, 8'h00, 1'b0, cur);
    cmd(8'h01, 8'hBC, 1'b1, 8'hBF);
    done(8'hBC);
    @(negedge clk_sys) wp_pin_n = 1'b0;
    cmd(8'h06, 8'h00, 1'b1, 8'hBE);
    cmd(8'h01, 8'h00, 1'b0, cur);
    @(negedge clk_sys) wp_pin_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    cmd(8'h01, 8'h00, 1'b1, 8'h03);
    done(8'h00);
    cmd(8'h06, 8'h00, 1'b1, 8'h02);
    cmd(8'h02, 8'h00, 1'b1, 8'h03);
    cmd(8'h75, 8'h00, 1'b1, 8'h02);
    cmd(8'h7A, 8'h00, 1'b1, 8'h03);
    done(8'h00);
    foreach (gated_codes[i]) begin
      // host enables writes ahead of every gated code
      cmd(8'h06, 8'h00, 1'b1, 8'h02);
      if (gated_codes[i] == 8'h83 || gated_codes[i] == 8'h4A) begin
        cmd(gated_codes[i], 8'h00, 1'b1, 8'h02);
      end else begin
        cmd(gated_codes[i], 8'h00, 1'b1, 8'h03);
        done(8'h00);
      end
    end
    chk(16'(notes.size()), 16'h0000, "forwards still pending");
    conclude();
  end
endmodule // flash_status_write_enable_tb
